/* src/pll_prog_pkg.sv */
// Purpose: shared constants for the synthesizer programming controller
// Assumes: 10 MHz system clock, host-made serial clock
// Notes:   host config words keep device field positions in bits 31:4
package pll_prog_pkg;

   // host register byte offsets on the bus
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SETUP = 8'h04;
   localparam logic [7:0] OFS_CAL = 8'h08;
   localparam logic [7:0] OFS_DIV = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // device register address codes, low nibble of each word
   localparam logic [3:0] DEV_ADDR_SETUP = 4'h0;
   localparam logic [3:0] DEV_ADDR_CAL = 4'h1;
   localparam logic [3:0] DEV_ADDR_DIV = 4'h2;

   // control register bits
   localparam int CTRL_CHIP_EN = 0;
   localparam int CTRL_POWER_UP = 1;
   localparam int CTRL_FREQ = 2;
   localparam int CTRL_SOFT_RST = 3;

   // status register bits
   localparam int STAT_BUSY = 0;
   localparam int STAT_CAL_RUN = 1;
   localparam int STAT_CAL_DONE = 2;
   localparam int STAT_RANGE_ERR = 3;
   localparam int STAT_REFUSED = 4;
   localparam int STAT_DATA_IN = 5;

   // device word field positions
   localparam int SU_SOFT_RST = 4;
   localparam int CAL_START = 31;
   localparam int DIV_LOCK_LOAD = 29;
   localparam int DIV_MAIN_LSB = 12;
   localparam int DIV_MAIN_W = 13;
   localparam int DIV_SWAL_LSB = 6;
   localparam int DIV_SWAL_W = 6;

   // writable bits and reset values of the config words
   localparam logic [31:0] SETUP_MASK = 32'h1fff_ffe0;
   localparam logic [31:0] CAL_MASK = 32'h7fff_fff0;
   localparam logic [31:0] DIV_MASK = 32'h1fff_fff0;
   localparam logic [31:0] SETUP_RESET = 32'h1000_0000;
   localparam logic [31:0] CAL_RESET = 32'h0000_0000;
   localparam logic [31:0] DIV_RESET = 32'h0000_0000;

   // field codes
   localparam logic [1:0] PRESC_8_9 = 2'h0;
   localparam logic [1:0] PRESC_16_17 = 2'h1;
   localparam logic [1:0] PRESC_32_33 = 2'h2;
   localparam logic [1:0] PRESC_64_65 = 2'h3;
   localparam logic [3:0] TEST_LOCK_DETECT = 4'h1;
   localparam logic [1:0] OUT_DIV4 = 2'h2;
   localparam logic [12:0] MAIN_MIN = 13'h0003;

   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int CAL_TIME_NS = 5000000;
   localparam int CAL_CYCLES =
      (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SER_HALF_CYCLES = 2;
   localparam int WORD_BITS = 32;

   // sequencer states
   typedef enum logic [6:0] {
      ST_IDLE   = 7'b0000001,
      ST_SETUP  = 7'b0000010,
      ST_CAL    = 7'b0000100,
      ST_WAIT   = 7'b0001000,
      ST_DIV    = 7'b0010000,
      ST_RST_HI = 7'b0100000,
      ST_RST_LO = 7'b1000000
   } seq_state_t;

endpackage : pll_prog_pkg

/* src/serial_word_shifter.sv */
// Purpose: shifts one 32-bit word out on clock/data, then pulses strobe
// Assumes: device samples data on the rising serial clock edge
// Notes:   data changes while the serial clock is low
`timescale 1ns/1ns
module serial_word_shifter
   import pll_prog_pkg::*;
#(
   parameter int HALF_CYCLES = SER_HALF_CYCLES
)
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // word request
   input wire logic i_start,
   input wire logic [31:0] i_word,
   output logic o_busy,
   output logic o_done,
   // serial pins
   output logic o_sclk,
   output logic o_sdata,
   output logic o_strobe
);

   // phases: 0..63 clock halves, 64 gap, 65 strobe, 66 trailing gap
   localparam logic [6:0] PH_STROBE = 7'h41;
   localparam logic [6:0] PH_LAST = 7'h42;
   localparam logic [6:0] PH_BITS = 7'h40;

   logic busy_q;
   logic done_q;
   logic [7:0] div_q;
   logic [6:0] ph_q;
   logic [31:0] sh_q;
   logic sclk_q;
   logic sdata_q;
   logic strobe_q;
   logic tick;

   assign tick = (div_q == 8'(HALF_CYCLES - 1));

   // phase walk; a start while busy is ignored by design
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         div_q <= 8'h00;
         ph_q <= 7'h00;
         sh_q <= 32'h0000_0000;
      end
      else
      begin
         done_q <= 1'b0;
         if (!busy_q)
         begin
            if (i_start)
            begin
               busy_q <= 1'b1;
               div_q <= 8'h00;
               ph_q <= 7'h00;
               sh_q <= i_word;
            end
         end
         else if (tick)
         begin
            div_q <= 8'h00;
            ph_q <= ph_q + 7'h01;
            // next bit goes out after the high half, msb first
            if (ph_q[0] && ph_q < PH_BITS - 7'h01)
               sh_q <= {sh_q[30:0], 1'b0}; // R25
            if (ph_q == PH_LAST)
            begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
         else
            div_q <= div_q + 8'h01;
      end
   end

   // registered pins avoid decode glitches reaching the device
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         sclk_q <= 1'b0;
         sdata_q <= 1'b0;
         strobe_q <= 1'b0;
      end
      else
      begin
         sclk_q <= busy_q && ph_q < PH_BITS && ph_q[0];
         sdata_q <= busy_q && sh_q[31];
         strobe_q <= busy_q && ph_q == PH_STROBE; // R25
      end
   end

   assign o_busy = busy_q;
   assign o_done = done_q;
   assign o_sclk = sclk_q;
   assign o_sdata = sdata_q;
   assign o_strobe = strobe_q;

endmodule : serial_word_shifter

/* src/pll_divider_program_ctrl.sv */
// Purpose: host controller programming an integer-N synthesizer
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes:   commands run power-up, frequency change and soft reset
//
// Overview of operation
// (R1) 32-bit words, low nibble selects register
// (R2) address 0010 goes to divider counters
// (R3) main counter bits 24:12, range 3..8191
// (R4) swallow counter bits 11:6, range 0..63
// (R5) main value must not be below swallow
// (R6) prescaler bits 5:4 select modulus pair
// (R7) divider values wait for lock-load bit
// (R8) device clears lock-load bit after lock
// (R9) test select 0001 shows lock detect
// (R10) counters and prescaler form feedback divider
// (R11) reference divider ratio 1..16383
// (R12) reference ratio in setup bits 25:12
// (R13) setup bits 7:5 scale pump current
// (R14) setup bits 9:8 pick output division
// (R15) setup bits 11:10 default 00, internal buffer
// (R16) soft reset: write setup twice, set then clear
// (R17) setup defaults: polarity one, rest zero
// (R18) reference MHz bits 10:4, hundredths 17:11
// (R19) calibration bits 30:18 target MHz
// (R20) start bit 31 runs 5 ms calibration
// (R21) no calibration/divider writes while calibrating
// (R22) later calibration writes keep start bit zero
// (R23) power-up: enable, setup, then calibration
// (R24) first lock-load zero, later changes one
// (R25) word msb first, strobe commits it
`timescale 1ns/1ns
module pll_divider_program_ctrl
   import pll_prog_pkg::*;
#(
   parameter int CAL_WAIT_CYCLES = CAL_CYCLES,
   parameter int HALF_CYCLES = SER_HALF_CYCLES
)
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   // synthesizer pins
   output logic o_chip_en,
   output logic o_ser_clk,
   output logic o_ser_strobe,
   output logic o_ser_data,
   output logic o_ser_data_oe,
   input wire logic i_ser_data
);

   // bus state
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [31:0] rdata_q;
   logic addr_phase;
   logic wr_ctrl;
   logic wr_status;

   // software registers
   logic chip_en_q;
   logic [31:0] setup_q;
   logic [31:0] cal_q;
   logic [31:0] div_q;
   logic range_err_q;
   logic refused_q;

   // sequencer
   seq_state_t state_q;
   logic sent_q;
   logic freq_mode_q;
   logic cal_done_q;
   logic [31:0] wait_q;
   logic cmd_power_up;
   logic cmd_freq;
   logic cmd_soft_rst;
   logic any_cmd;
   logic range_ok;
   logic send_state;
   logic shift_start;
   logic shift_busy;
   logic shift_done;
   logic [31:0] word;
   logic [31:0] status;
   logic [12:0] main_val;
   logic [5:0] swal_val;

   // readback line synchroniser
   logic din_meta_q;
   logic din_sync_q;

   // address phase of a selected, non-idle transfer
   assign addr_phase = i_hsel && i_htrans[1] && i_hready;

   // write data arrives one cycle after its address is taken
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end
      else if (i_hready)
      begin
         wr_pend_q <= addr_phase && i_hwrite;
         wr_addr_q <= i_haddr[7:0];
      end
   end

   // read data latched at the address phase, shown in the data phase
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         rdata_q <= 32'h0000_0000;
      else if (addr_phase && !i_hwrite)
      begin
         case (i_haddr[7:0])
            OFS_CTRL: rdata_q <= {31'h0000_0000, chip_en_q};
            OFS_SETUP: rdata_q <= setup_q;
            OFS_CAL: rdata_q <= cal_q;
            OFS_DIV: rdata_q <= div_q;
            OFS_STATUS: rdata_q <= status;
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // never stalls, always okay; unmapped reads return zero
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign o_hrdata = rdata_q;

   assign wr_ctrl = wr_pend_q && wr_addr_q == OFS_CTRL;
   assign wr_status = wr_pend_q && wr_addr_q == OFS_STATUS;

   // configuration words keep device bit positions; address and
   // self-clearing bits are owned by the sequencer, not software
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         chip_en_q <= 1'b0;
         setup_q <= SETUP_RESET; // R17
         cal_q <= CAL_RESET;
         div_q <= DIV_RESET;
      end
      else if (wr_pend_q)
      begin
         case (wr_addr_q)
            OFS_CTRL: chip_en_q <= i_hwdata[CTRL_CHIP_EN];
            OFS_SETUP: setup_q <= i_hwdata & SETUP_MASK; // R12
            OFS_CAL: cal_q <= i_hwdata & CAL_MASK; // R18
            OFS_DIV: div_q <= i_hwdata & DIV_MASK; // R3
            default: ;
         endcase
      end
   end

   assign o_chip_en = chip_en_q;

   // command strobes from control register writes
   assign cmd_power_up = wr_ctrl && i_hwdata[CTRL_POWER_UP];
   assign cmd_freq = wr_ctrl && i_hwdata[CTRL_FREQ];
   assign cmd_soft_rst = wr_ctrl && i_hwdata[CTRL_SOFT_RST];
   assign any_cmd = cmd_power_up || cmd_freq || cmd_soft_rst;

   // divider value checks before anything reaches the device
   assign main_val = div_q[DIV_MAIN_LSB +: DIV_MAIN_W];
   assign swal_val = div_q[DIV_SWAL_LSB +: DIV_SWAL_W]; // R4
   assign range_ok = main_val >= MAIN_MIN // R3
      && main_val >= {7'h00, swal_val}; // R5

   // sticky error flags, write one to clear, a new event wins
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         range_err_q <= 1'b0;
         refused_q <= 1'b0;
      end
      else
      begin
         if ((cmd_power_up || cmd_freq) && state_q == ST_IDLE
            && chip_en_q && !range_ok)
            range_err_q <= 1'b1;
         else if (wr_status && i_hwdata[STAT_RANGE_ERR])
            range_err_q <= 1'b0;
         // commands while busy or disabled, and frequency changes before calibration
         if (any_cmd && (state_q != ST_IDLE || !chip_en_q
            || (cmd_freq && !cal_done_q)))
            refused_q <= 1'b1; // R21
         else if (wr_status && i_hwdata[STAT_REFUSED])
            refused_q <= 1'b0;
      end
   end

   // sequencer: one word per sending state, then the next state
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_q <= ST_IDLE;
         sent_q <= 1'b0;
         freq_mode_q <= 1'b0;
         cal_done_q <= 1'b0;
         wait_q <= 32'h0000_0000;
      end
      else
      begin
         if (shift_start)
            sent_q <= 1'b1;
         else if (shift_done)
            sent_q <= 1'b0;
         case (state_q)
            ST_IDLE:
            begin
               if (chip_en_q && cmd_soft_rst)
                  state_q <= ST_RST_HI; // R16
               else if (chip_en_q && cmd_power_up && range_ok)
               begin
                  freq_mode_q <= 1'b0;
                  state_q <= ST_SETUP; // R23
               end
               else if (chip_en_q && cmd_freq && range_ok
                  && cal_done_q)
               begin
                  freq_mode_q <= 1'b1;
                  state_q <= ST_CAL;
               end
            end
            ST_SETUP:
               if (shift_done)
                  state_q <= ST_CAL; // R23
            ST_CAL:
               if (shift_done)
               begin
                  wait_q <= 32'h0000_0000;
                  // a plain retune does not calibrate, so no wait
                  state_q <= freq_mode_q ? ST_DIV : ST_WAIT;
               end
            ST_WAIT:
            begin
               // calibration and divider writes would be ignored now
               wait_q <= wait_q + 32'h0000_0001;
               if (wait_q == 32'(CAL_WAIT_CYCLES - 1))
                  state_q <= ST_DIV; // R21
            end
            ST_DIV:
               if (shift_done)
               begin
                  cal_done_q <= 1'b1;
                  state_q <= ST_IDLE;
               end
            ST_RST_HI:
               if (shift_done)
                  state_q <= ST_RST_LO; // R16
            ST_RST_LO:
               if (shift_done)
               begin
                  // device lost its calibration data
                  cal_done_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
            default: state_q <= ST_IDLE;
         endcase
         // a dropped chip enable abandons the calibration state
         if (!chip_en_q)
            cal_done_q <= 1'b0;
      end
   end

   assign send_state = state_q == ST_SETUP || state_q == ST_CAL
      || state_q == ST_DIV || state_q == ST_RST_HI
      || state_q == ST_RST_LO;
   assign shift_start = send_state && !sent_q && !shift_busy;

   // word assembly; field bits come straight from software words
   always_comb
   begin
      word = 32'h0000_0000;
      case (state_q)
         ST_SETUP:
            word = {setup_q[31:5], 1'b0, DEV_ADDR_SETUP}; // R1
         ST_RST_HI:
            word = {setup_q[31:5], 1'b1, DEV_ADDR_SETUP}; // R16
         ST_RST_LO:
            word = {setup_q[31:5], 1'b0, DEV_ADDR_SETUP}; // R16
         ST_CAL:
         begin
            word = {cal_q[31:4], DEV_ADDR_CAL}; // R19
            word[CAL_START] = !freq_mode_q; // R20 R22
         end
         ST_DIV:
         begin
            word = {div_q[31:4], DEV_ADDR_DIV}; // R2
            word[DIV_LOCK_LOAD] = freq_mode_q; // R7 R24
         end
         default: word = 32'h0000_0000;
      endcase
   end

   // serial engine for the three-wire link
   serial_word_shifter #(
      .HALF_CYCLES(HALF_CYCLES)
   ) u_shifter (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_start(shift_start),
      .i_word(word),
      .o_busy(shift_busy),
      .o_done(shift_done),
      .o_sclk(o_ser_clk),
      .o_sdata(o_ser_data),
      .o_strobe(o_ser_strobe) // R25
   );

   // data pin only driven while a word is on the wire
   assign o_ser_data_oe = shift_busy;

   // two-flop synchroniser for the shared data line
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         din_meta_q <= 1'b0;
         din_sync_q <= 1'b0;
      end
      else
      begin
         din_meta_q <= i_ser_data;
         din_sync_q <= din_meta_q;
      end
   end

   // status word
   always_comb
   begin
      status = 32'h0000_0000;
      status[STAT_BUSY] = state_q != ST_IDLE;
      status[STAT_CAL_RUN] = state_q == ST_WAIT; // R20
      status[STAT_CAL_DONE] = cal_done_q;
      status[STAT_RANGE_ERR] = range_err_q;
      status[STAT_REFUSED] = refused_q;
      status[STAT_DATA_IN] = din_sync_q;
   end

endmodule : pll_divider_program_ctrl

/* bench/pll_prog_checker.sv */
// Purpose: port checks of the synthesizer programming controller
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   attached to every controller instance by bind
`timescale 1ns/1ns
module pll_prog_checker
#(
   parameter int HALF_CYCLES = 2
)
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // bus answer
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   // synthesizer pins
   input wire logic o_chip_en,
   input wire logic o_ser_clk,
   input wire logic o_ser_strobe,
   input wire logic o_ser_data,
   input wire logic o_ser_data_oe
);
   int hi_q;
   int rise_q;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);
   // high-half length and rising edges seen within the current word
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         hi_q <= 0;
         rise_q <= 0;
      end
      else
      begin
         hi_q <= o_ser_clk ? hi_q + 1 : 0;
         rise_q <= !o_ser_data_oe ? 0 : rise_q + int'(o_ser_clk && hi_q == 0);
      end
   end
   bus_answer_a: assert property (o_hreadyout && !o_hresp)
      else $error("bus answer not ready or not okay");
   clock_idle_a: assert property (
      !o_ser_data_oe |-> !o_ser_clk) else $error("serial clock outside word");
   data_steady_a: assert property (
      o_ser_clk |-> $stable(o_ser_data)) else $error("data moved in high half");
   high_half_a: assert property (
      $fell(o_ser_clk) |-> hi_q == HALF_CYCLES) else $error("bad high half");
   word_length_a: assert property (
      $rose(o_ser_strobe) |-> rise_q == 32) else $error("word not 32 bits");
   strobe_gap_a: assert property (
      o_ser_strobe |-> !o_ser_clk && o_ser_data_oe)
      else $error("strobe overlaps clock");
   strobe_width_a: assert property (
      $rose(o_ser_strobe) |=> o_ser_strobe ##1 !o_ser_strobe)
      else $error("strobe width wrong");
   pin_release_a: assert property (
      $fell(o_ser_strobe) |-> ##[1:4] !o_ser_data_oe)
      else $error("data pin not released");
   enable_first_a: assert property (
      o_ser_data_oe |-> o_chip_en) else $error("word sent while disabled");
endmodule : pll_prog_checker

bind pll_divider_program_ctrl pll_prog_checker #(.HALF_CYCLES(HALF_CYCLES))
   chk (.i_clock(i_clock), .i_rst(i_rst), .o_hreadyout(o_hreadyout),
   .o_hresp(o_hresp), .o_chip_en(o_chip_en), .o_ser_clk(o_ser_clk),
   .o_ser_strobe(o_ser_strobe), .o_ser_data(o_ser_data),
   .o_ser_data_oe(o_ser_data_oe));

/* bench/synth_device_model.sv */
// Purpose: behavioural synthesizer behind the three-wire port
// Assumes: bits taken msb first on rising serial clock, strobe commits
// Notes:   calibration and lock times shortened by parameters
`timescale 1ns/1ns
module synth_device_model
   import pll_prog_pkg::*;
#(
   parameter int CAL_TIME = 20,
   parameter int LOCK_TIME = 6
)
(
   // power and pins
   input wire logic i_rst,
   input wire logic i_clock,
   input wire logic i_chip_en,
   input wire logic i_sclk,
   input wire logic i_strobe,
   input wire logic i_data,
   // data pin level while the host is not driving
   output logic o_data
);
   logic [31:0] shift_q;
   logic [31:0] setup_q;
   logic [31:0] cal_q;
   logic [31:0] div_q;
   logic [24:0] act_q;
   logic sclk_q;
   logic strobe_q;
   int cal_cnt_q;
   int lock_cnt_q;
   int refused_q;
   logic [31:0] log_q [$];
   // released pin shows the inverse of the last bit, never a held copy
   assign o_data = ~shift_q[0];
   // shifting, commits and the two self-clearing bits
   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         {shift_q, cal_q, div_q, act_q, sclk_q, strobe_q} <= '0;
         setup_q <= SETUP_RESET;
         cal_cnt_q <= 0;
         lock_cnt_q <= 0;
         refused_q <= 0;
      end
      else
      begin
         sclk_q <= i_sclk;
         strobe_q <= i_strobe;
         if (i_chip_en && i_sclk && !sclk_q)
            shift_q <= {shift_q[30:0], i_data};
         if (cal_cnt_q == 1)
            cal_q[31] <= 1'b0;
         if (cal_cnt_q > 0)
            cal_cnt_q <= cal_cnt_q - 1;
         if (lock_cnt_q == 1)
            div_q[29] <= 1'b0;
         if (lock_cnt_q > 0)
            lock_cnt_q <= lock_cnt_q - 1;
         if (i_chip_en && i_strobe && !strobe_q)
         begin
            log_q.push_back(shift_q);
            if (shift_q[3:0] == 4'h0 && shift_q[4])
            begin
               setup_q <= SETUP_RESET;
               cal_q <= '0;
               div_q <= '0;
               act_q <= '0;
            end
            else if (shift_q[3:0] == 4'h0)
               setup_q <= shift_q;
            else if (cal_cnt_q > 0)
               refused_q <= refused_q + 1;
            else if (shift_q[3:0] == 4'h1)
            begin
               cal_q <= shift_q;
               if (shift_q[31])
                  cal_cnt_q <= CAL_TIME;
            end
            else if (shift_q[3:0] == 4'h2)
            begin
               div_q <= shift_q;
               if (shift_q[29])
               begin
                  act_q <= shift_q[28:4];
                  lock_cnt_q <= LOCK_TIME;
               end
            end
         end
      end
   end
endmodule : synth_device_model

/* bench/tb.sv */
// Purpose: self-checking bench of the synthesizer programming controller
// Assumes: AHB-Lite master tasks, device model on the serial pins
// Notes:   calibration wait shortened to 20 clocks
`timescale 1ns/1ns
module tb;
   import pll_prog_pkg::*;
   localparam logic [31:0] SU_VAL = 32'h1020_02a0; // ratio 512, n 5, div 4
   localparam logic [31:0] CAL_VAL = 32'h2262_41e0; // 30.72 in, 2200 out
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic i_hsel = 1'b0;
   logic [31:0] i_haddr = '0;
   logic [1:0] i_htrans = 2'h0;
   logic i_hwrite = 1'b0;
   logic [2:0] i_hsize = 3'h2;
   logic [31:0] i_hwdata = '0;
   logic o_hreadyout, o_hresp, o_chip_en, o_ser_clk, o_ser_strobe;
   logic o_ser_data, o_ser_data_oe, dev_pin, data_wire;
   logic [31:0] o_hrdata;
   logic [31:0] v;
   int n0;
   int fail_count = 0;
   int compares = 0;
   always #50 i_clock = ~i_clock;
   // resolved data line: host while enabled, otherwise the device
   assign data_wire = o_ser_data_oe ? o_ser_data : dev_pin;
   pll_divider_program_ctrl #(.CAL_WAIT_CYCLES(20), .HALF_CYCLES(2)) dut (
      .i_clock(i_clock), .i_rst(i_rst), .i_hsel(i_hsel),
      .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
      .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
      .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
      .o_chip_en(o_chip_en), .o_ser_clk(o_ser_clk),
      .o_ser_strobe(o_ser_strobe), .o_ser_data(o_ser_data),
      .o_ser_data_oe(o_ser_data_oe), .i_ser_data(data_wire));
   synth_device_model #(.CAL_TIME(20), .LOCK_TIME(6)) dev (.i_rst(i_rst),
      .i_clock(i_clock), .i_chip_en(o_chip_en), .i_sclk(o_ser_clk),
      .i_strobe(o_ser_strobe), .i_data(data_wire), .o_data(dev_pin));
   function automatic logic [31:0] mk_div(input logic [12:0] m,
      input logic [5:0] a, input logic [1:0] p);
      return {3'h0, TEST_LOCK_DETECT, m, a, p, DEV_ADDR_DIV};
   endfunction : mk_div
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // no cycle count assumed; only the watchdog ends a stuck wait
   task automatic wait_ready();
      do
         @(posedge i_clock);
      while (o_hreadyout !== 1'b1);
   endtask : wait_ready
   // address phase held until ready, then data phase until ready again
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      i_hsel <= 1'b1;
      i_haddr <= {24'h0, a};
      i_hwrite <= wr;
      i_htrans <= 2'h2;
      wait_ready();
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= wd;
      wait_ready();
      rd = o_hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      check(x, exp);
   endtask : rd_chk
   task automatic wait_idle();
      v = 32'h1;
      while (v[STAT_BUSY] !== 1'b0)
         bus(1'b0, OFS_STATUS, 32'h0, v);
   endtask : wait_idle
   task automatic t_regs();
      rd_chk(OFS_SETUP, SETUP_RESET);
      rd_chk(OFS_CAL, CAL_RESET);
      rd_chk(OFS_DIV, DIV_RESET);
      wr(8'h20, 32'hffff_ffff);
      rd_chk(8'h20, 32'h0);
      wr(OFS_SETUP, 32'hffff_ffff);
      rd_chk(OFS_SETUP, SETUP_MASK);
      wr(OFS_CTRL, 32'h2);
      rd_chk(OFS_STATUS, 32'h30);
      check({31'h0, o_chip_en}, 32'h0);
      wr(OFS_STATUS, 32'h10);
   endtask : t_regs
   task automatic t_power();
      wr(OFS_SETUP, SU_VAL);
      wr(OFS_CAL, CAL_VAL);
      wr(OFS_DIV, mk_div(13'h232, 6'h4, PRESC_16_17));
      wr(OFS_CTRL, 32'h1);
      n0 = dev.log_q.size();
      wr(OFS_CTRL, 32'h3);
      wr(OFS_CTRL, 32'h5);
      bus(1'b0, OFS_STATUS, 32'h0, v);
      check(v & 32'h10, 32'h10);
      check({31'h0, o_chip_en}, 32'h1);
      wait_idle();
      check(dev.log_q[n0], SU_VAL & SETUP_MASK);
      check(dev.log_q[n0 + 1], CAL_VAL | 32'h8000_0001);
      check(dev.log_q[n0 + 2], mk_div(13'h232, 6'h4, PRESC_16_17));
      check({7'h0, dev.act_q}, 32'h0);
      wr(OFS_STATUS, 32'h10);
      rd_chk(OFS_STATUS, 32'h24);
   endtask : t_power
   task automatic t_range();
      n0 = dev.log_q.size();
      wr(OFS_DIV, mk_div(13'h2, 6'h0, PRESC_8_9));
      wr(OFS_CTRL, 32'h5);
      repeat (2) @(posedge i_clock);
      rd_chk(OFS_STATUS, 32'h2c);
      wr(OFS_STATUS, 32'h08);
      wr(OFS_DIV, mk_div(13'h5, 6'h6, PRESC_8_9));
      wr(OFS_CTRL, 32'h5);
      repeat (2) @(posedge i_clock);
      rd_chk(OFS_STATUS, 32'h2c);
      wr(OFS_STATUS, 32'h08);
      check(32'(dev.log_q.size()), 32'(n0));
   endtask : t_range
   // every prescaler code with counter values at their limits, except the mid-range main value 13'h484
   task automatic t_freq();
      logic [12:0] m [4] = '{13'h3, 13'h1fff, 13'h484, 13'h3f};
      logic [5:0] a [4] = '{6'h3, 6'h3f, 6'h0, 6'h3f};
      logic [31:0] w;
      for (int i = 0; i < 4; i++)
      begin
         w = mk_div(m[i], a[i], 2'(i));
         wr(OFS_DIV, w);
         n0 = dev.log_q.size();
         wr(OFS_CTRL, 32'h5);
         wait_idle();
         check(dev.log_q[n0], CAL_VAL | 32'h1);
         check(dev.log_q[n0 + 1], w | 32'h2000_0000);
         check({7'h0, dev.act_q}, {7'h0, w[28:4]});
         repeat (8) @(posedge i_clock);
         check({31'h0, dev.div_q[29]}, 32'h0);
      end
   endtask : t_freq
   task automatic t_soft();
      n0 = dev.log_q.size();
      wr(OFS_CTRL, 32'h9);
      wait_idle();
      check(dev.log_q[n0], (SU_VAL & SETUP_MASK) | 32'h10);
      check(dev.log_q[n0 + 1], SU_VAL & SETUP_MASK);
      check(dev.cal_q, 32'h0);
      wr(OFS_CTRL, 32'h5);
      repeat (2) @(posedge i_clock);
      rd_chk(OFS_STATUS, 32'h30);
   endtask : t_soft
   task automatic finish_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test
   // a hang stops the run well past the expected length
   initial
   begin
      #2000000;
      fail_count++;
      finish_test();
   end
   initial
   begin
      repeat (3) @(posedge i_clock);
      i_rst <= 1'b0;
      t_regs();
      t_power();
      t_range();
      t_freq();
      t_soft();
      check(32'(dev.refused_q), 32'h0);
      finish_test();
   end
endmodule : tb
